// ---- core/txl_pkg.sv ----
// ****************************************************************************
// shared constants
// ****************************************************************************
package txl_pkg;

  // lane and data geometry
  localparam int LANES     = 4;
  localparam int LANE_W    = 40;
  localparam int PIX_W     = 24;
  localparam int PIX_FRL   = 8;
  localparam int PIX_TMDS  = 2;
  localparam int VID_W     = PIX_W * PIX_FRL;
  localparam int CHAR_W    = 18;
  localparam int SLOT_W    = 32;
  localparam int AUD_SLOTS = 8;
  localparam int AUD_W     = SLOT_W * AUD_SLOTS;
  localparam int PAT_SEL_W = 4;

  // register map, byte addresses
  localparam int         ADDR_W     = 4;
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h4;
  localparam logic [3:0] OFS_WORDS  = 4'h8;
  localparam logic [3:0] OFS_CHARS  = 4'hC;

  // control register fields
  localparam int         CTRL_W     = 10;
  localparam int         CTRL_RATIO = 0;
  localparam int         CTRL_FRL   = 1;
  localparam int         CTRL_WSEL  = 2;
  localparam int         CTRL_RATE  = 4;
  localparam int         CTRL_MST   = 7;
  localparam int         CTRL_GRP   = 8;
  localparam logic [9:0] CTRL_RST   = 10'h000;

  // clock-channel words per clock select
  localparam logic [1:0] WSEL_1 = 2'h0;
  localparam logic [1:0] WSEL_2 = 2'h1;

  // clock-channel symbols
  localparam logic [9:0]  SYM_CONST = 10'h3E0;
  localparam logic [9:0]  SYM_ZERO  = 10'h000;
  localparam logic [9:0]  SYM_ONE   = 10'h3FF;
  localparam logic [19:0] W2_ZERO   = 20'h00000;
  localparam logic [19:0] W2_ONE    = 20'hFFFFF;
  localparam logic [39:0] W4_WORD   = 40'hFFFFF00000;

  // fixed-rate lanes
  localparam logic [2:0] RATE_3LANE_MAX = 3'h2;
  localparam logic [9:0] BITS_3LANE     = 10'h078;
  localparam logic [9:0] BITS_4LANE     = 10'h0A0;

  // training patterns
  localparam logic [3:0]  PAT_ZERO = 4'h0;
  localparam logic [3:0]  PAT_ONE  = 4'h1;
  localparam logic [3:0]  PAT_ALT  = 4'h2;
  localparam logic [3:0]  PAT_PRBS = 4'h3;
  localparam logic [39:0] ALT_WORD = 40'h5555555555;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- core/txl_pat_if.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// lane pattern carrier
// ****************************************************************************
interface txl_pat_if;
  logic        step;
  logic [3:0]  sel;
  logic [39:0] data;
  modport gen  (input step, input sel, output data);
  modport user (output step, output sel, input data);
endinterface
`default_nettype wire

// ---- core/txl_pat_gen.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************************
// per-lane training pattern source
// ****************************************************************************
module txl_pat_gen #(
  parameter logic [15:0] SEED = 16'h0001
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pattern carrier
  txl_pat_if.gen   pat
);

  typedef struct packed {
    logic [15:0] lfsr;
    logic [39:0] data;
  } txl_pg_st_t;

  txl_pg_st_t st_r;
  txl_pg_st_t st_nxt;

  assign pat.data = st_r.data;

  always_comb
  begin
    st_nxt = st_r;
    if (pat.step)
    begin
      st_nxt.lfsr = {st_r.lfsr[14:0], st_r.lfsr[15] ^ st_r.lfsr[13] ^ st_r.lfsr[12] ^ st_r.lfsr[10]};
    end
    unique case (pat.sel)
      txl_pkg::PAT_ZERO: st_nxt.data = '0;
      txl_pkg::PAT_ONE:  st_nxt.data = '1;
      txl_pkg::PAT_ALT:  st_nxt.data = txl_pkg::ALT_WORD;
      txl_pkg::PAT_PRBS: st_nxt.data = {st_r.lfsr[7:0], st_r.lfsr, st_r.lfsr};
      default:           st_nxt.data = '0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r      <= '0;
      st_r.lfsr <= SEED;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule
`default_nettype wire

// ---- core/txl_out.sv ----
// Our own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module txl_out #(
  parameter int FRL_CHARS = 8
) (
  // clock and reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // axi4-lite slave
  input  wire logic [txl_pkg::ADDR_W-1:0]           s_axi_awaddr,
  input  wire logic                                 s_axi_awvalid,
  output logic                                      s_axi_awready,
  input  wire logic [31:0]                          s_axi_wdata,
  input  wire logic [3:0]                           s_axi_wstrb,
  input  wire logic                                 s_axi_wvalid,
  output logic                                      s_axi_wready,
  output logic [1:0]                                s_axi_bresp,
  output logic                                      s_axi_bvalid,
  input  wire logic                                 s_axi_bready,
  input  wire logic [txl_pkg::ADDR_W-1:0]           s_axi_araddr,
  input  wire logic                                 s_axi_arvalid,
  output logic                                      s_axi_arready,
  output logic [31:0]                               s_axi_rdata,
  output logic [1:0]                                s_axi_rresp,
  output logic                                      s_axi_rvalid,
  input  wire logic                                 s_axi_rready,
  // link side
  input  wire logic                                 link_speed_clock,
  input  wire logic                                 training_start,
  input  wire logic [txl_pkg::LANES*4-1:0]          lane_pattern,
  output logic [txl_pkg::LANES*txl_pkg::LANE_W-1:0] lane_data,
  output logic                                      lane_strobe,
  output logic                                      frl_char_req,
  // video
  input  wire logic [txl_pkg::VID_W-1:0]            vid_data,
  input  wire logic                                 vid_valid,
  output logic [txl_pkg::VID_W-1:0]                 vid_word,
  // audio
  input  wire logic [txl_pkg::AUD_W-1:0]            audio_in,
  input  wire logic                                 audio_valid,
  output logic [txl_pkg::AUD_W-1:0]                 audio_word,
  output logic                                      audio_word_valid,
  output logic [5:0]                                audio_first_channel
);

  localparam logic [9:0] CHAR_THR = 10'(txl_pkg::CHAR_W * FRL_CHARS);
  localparam int         TMDS_W   = txl_pkg::PIX_W * txl_pkg::PIX_TMDS;

  if (FRL_CHARS != 8 && FRL_CHARS != 16)
  begin : g_chk
    $error("FRL_CHARS must be 8 or 16");
  end

  typedef struct packed {
    logic                                    lk_s1;
    logic                                    lk_s2;
    logic                                    lk_s3;
    logic [1:0]                              phase;
    logic [txl_pkg::LANES-1:0][39:0]         lane;
    logic                                    strobe;
    logic [txl_pkg::VID_W-1:0]               vid_hold;
    logic [txl_pkg::AUD_W-1:0]               aud_word;
    logic                                    aud_valid;
    logic [9:0]                              char_acc;
    logic                                    char_req;
    logic [15:0]                             char_cnt;
    logic [31:0]                             word_cnt;
    logic [txl_pkg::CTRL_W-1:0]              ctrl;
    logic                                    awv;
    logic [txl_pkg::ADDR_W-1:0]              awaddr;
    logic                                    wv;
    logic [31:0]                             wdata;
    logic [3:0]                              wstrb;
    logic                                    bvalid;
    logic [1:0]                              bresp;
    logic                                    rvalid;
    logic [31:0]                             rdata;
    logic [1:0]                              rresp;
  } txl_st_t;

  txl_st_t                         st_r;
  txl_st_t                         st_nxt;
  logic                            link_edge;
  logic                            ratio;
  logic                            frl_on;
  logic                            mst_on;
  logic [1:0]                      wsel;
  logic [2:0]                      rate;
  logic                            three_lane;
  logic [3:0]                      lane_mask;
  logic [txl_pkg::LANES-1:0][39:0] pat_data;
  logic [39:0]                     clk_word;
  logic [9:0]                      lane_bits;
  logic [10:0]                     char_sum;

  // ****************************************************************************
  // configuration decode
  // ****************************************************************************
  assign ratio      = st_r.ctrl[txl_pkg::CTRL_RATIO];
  assign frl_on     = st_r.ctrl[txl_pkg::CTRL_FRL];
  assign mst_on     = st_r.ctrl[txl_pkg::CTRL_MST];
  assign wsel       = st_r.ctrl[txl_pkg::CTRL_WSEL +: 2];
  assign rate       = st_r.ctrl[txl_pkg::CTRL_RATE +: 3];
  assign three_lane = frl_on && (rate <= txl_pkg::RATE_3LANE_MAX);
  assign lane_mask  = (three_lane && training_start) ? 4'h7 : 4'hF;
  // sampled link clock rising edge
  assign link_edge  = st_r.lk_s2 && !st_r.lk_s3;

  // ****************************************************************************
  // training pattern sources
  // ****************************************************************************
  for (genvar g = 0; g < txl_pkg::LANES; g++)
  begin : g_lane
    txl_pat_if pif ();
    assign pif.step    = link_edge;
    assign pif.sel     = lane_pattern[g*4 +: 4];
    assign pat_data[g] = pif.data;
    txl_pat_gen #(
      .SEED (16'(16'hACE1 + g))
    ) u_pat (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pat     (pif)
    );
  end

  // ****************************************************************************
  // clock-channel word
  // ****************************************************************************
  always_comb
  begin
    if (!ratio)
    begin
      clk_word = {4{txl_pkg::SYM_CONST}};
    end
    else if (wsel == txl_pkg::WSEL_1)
    begin
      clk_word = {30'h00000000, (st_r.phase[1] ? txl_pkg::SYM_ONE : txl_pkg::SYM_ZERO)};
    end
    else if (wsel == txl_pkg::WSEL_2)
    begin
      clk_word = {20'h00000, (st_r.phase[0] ? txl_pkg::W2_ONE : txl_pkg::W2_ZERO)};
    end
    else
    begin
      clk_word = txl_pkg::W4_WORD;
    end
  end

  // ****************************************************************************
  // next state
  // ****************************************************************************
  // bits owed only on a link word; the deficit drains one batch per cycle
  assign lane_bits = link_edge ? (three_lane ? txl_pkg::BITS_3LANE : txl_pkg::BITS_4LANE) : 10'h000;
  assign char_sum  = {1'b0, st_r.char_acc} + {1'b0, lane_bits};

  always_comb
  begin
    st_nxt          = st_r;
    st_nxt.lk_s1    = link_speed_clock;
    st_nxt.lk_s2    = st_r.lk_s1;
    st_nxt.lk_s3    = st_r.lk_s2;
    st_nxt.strobe   = link_edge;
    st_nxt.char_req = 1'b0;
    // axi write channels, either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_nxt.awv    = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_nxt.wv    = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.awv && st_r.wv && !st_r.bvalid)
    begin
      st_nxt.awv    = 1'b0;
      st_nxt.wv     = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = txl_pkg::RESP_OKAY;
      if (st_r.awaddr[3:2] == txl_pkg::OFS_CTRL[3:2])
      begin
        if (st_r.wstrb[0])
        begin
          st_nxt.ctrl[7:0] = st_r.wdata[7:0];
        end
        if (st_r.wstrb[1])
        begin
          st_nxt.ctrl[9:8] = st_r.wdata[9:8];
        end
      end
      else if (st_r.awaddr[3:2] != txl_pkg::OFS_STATUS[3:2] && st_r.awaddr[3:2] != txl_pkg::OFS_WORDS[3:2]
               && st_r.awaddr[3:2] != txl_pkg::OFS_CHARS[3:2])
      begin
        st_nxt.bresp = txl_pkg::RESP_SLVERR;
      end
    end
    if (st_r.bvalid && s_axi_bready)
    begin
      st_nxt.bvalid = 1'b0;
    end
    // axi read
    if (st_r.rvalid && s_axi_rready)
    begin
      st_nxt.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp  = txl_pkg::RESP_OKAY;
      unique case (s_axi_araddr[3:2])
        txl_pkg::OFS_CTRL[3:2]:   st_nxt.rdata = {22'h000000, st_r.ctrl};
        txl_pkg::OFS_STATUS[3:2]: st_nxt.rdata = {24'h000000, st_r.lk_s2, st_r.phase, lane_mask, !training_start};
        txl_pkg::OFS_WORDS[3:2]:  st_nxt.rdata = st_r.word_cnt;
        txl_pkg::OFS_CHARS[3:2]:  st_nxt.rdata = {16'h0000, st_r.char_cnt};
      endcase
    end
    if (vid_valid)
    begin
      st_nxt.vid_hold = frl_on ? vid_data : {{(txl_pkg::VID_W-TMDS_W){1'b0}}, vid_data[TMDS_W-1:0]};
    end
    // audio slot packing
    st_nxt.aud_valid = audio_valid;
    if (audio_valid)
    begin
      if (mst_on)
      begin
        for (int s = 0; s < txl_pkg::AUD_SLOTS / 2; s++)
        begin
          st_nxt.aud_word[2*s*32 +: 32]     = audio_in[s*32 +: 32];
          st_nxt.aud_word[(2*s+1)*32 +: 32] = audio_in[(s+4)*32 +: 32];
        end
      end
      else
      begin
        st_nxt.aud_word = audio_in;
      end
    end
    if (link_edge)
    begin
      st_nxt.phase    = st_r.phase + 2'h1;
      st_nxt.word_cnt = st_r.word_cnt + 32'h00000001;
      for (int i = 0; i < txl_pkg::LANES; i++)
      begin
        if (!training_start)
        begin
          st_nxt.lane[i] = pat_data[i];
        end
        else
        begin
          st_nxt.lane[i] = st_r.vid_hold[i*txl_pkg::LANE_W +: txl_pkg::LANE_W];
        end
      end
      if (training_start && !frl_on)
      begin
        st_nxt.lane[3] = clk_word;
      end
      if (training_start && three_lane)
      begin
        st_nxt.lane[3] = '0;
      end
    end
    if (training_start && frl_on)
    begin
      if (char_sum >= {1'b0, CHAR_THR})
      begin
        st_nxt.char_acc = 10'(char_sum - {1'b0, CHAR_THR});
        st_nxt.char_req = 1'b1;
        st_nxt.char_cnt = st_r.char_cnt + 16'h0001;
      end
      else
      begin
        st_nxt.char_acc = char_sum[9:0];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r      <= '0;
      st_r.ctrl <= txl_pkg::CTRL_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************************
  // outputs
  // ****************************************************************************
  assign s_axi_awready       = !st_r.awv && !st_r.bvalid;
  assign s_axi_wready        = !st_r.wv && !st_r.bvalid;
  assign s_axi_bvalid        = st_r.bvalid;
  assign s_axi_bresp         = st_r.bresp;
  assign s_axi_arready       = !st_r.rvalid;
  assign s_axi_rvalid        = st_r.rvalid;
  assign s_axi_rdata         = st_r.rdata;
  assign s_axi_rresp         = st_r.rresp;
  assign lane_data           = st_r.lane;
  assign lane_strobe         = st_r.strobe;
  assign frl_char_req        = st_r.char_req;
  assign vid_word            = st_r.vid_hold;
  assign audio_word          = st_r.aud_word;
  assign audio_word_valid    = st_r.aud_valid;
  assign audio_first_channel = {1'b0, st_r.ctrl[txl_pkg::CTRL_GRP +: 2], 3'h0} + 6'h01;

  // ****************************************************************************
  // checks
  // ****************************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_w4_word;
    link_edge && training_start && !frl_on && ratio && wsel == 2'h2 |=> st_r.lane[3] == 40'hFFFFF00000;
  endproperty
  a_w4_word: assert property (p_w4_word) else $error("four-word clock pattern wrong");

  property p_w2_alt;
    link_edge && training_start && !frl_on && ratio && wsel == 2'h1 |=>
      st_r.lane[3][19:0] == ($past(st_r.phase[0]) ? 20'hFFFFF : 20'h00000);
  endproperty
  a_w2_alt: assert property (p_w2_alt) else $error("two-word clock pattern wrong");

  property p_w1_seq;
    link_edge && training_start && !frl_on && ratio && wsel == 2'h0 && st_r.phase == 2'h1 |=>
      st_r.lane[3][9:0] == 10'h000 ##[1:40] (st_r.strobe && st_r.lane[3][9:0] == 10'h3FF);
  endproperty
  a_w1_seq: assert property (p_w1_seq) else $error("one-word clock sequence wrong");

  property p_const;
    link_edge && training_start && !frl_on && !ratio |=> st_r.lane[3] == {4{10'h3E0}};
  endproperty
  a_const: assert property (p_const) else $error("constant clock word wrong");

  property p_lpcm;
    audio_valid && !mst_on |=> audio_word == $past(audio_in) && audio_word_valid;
  endproperty
  a_lpcm: assert property (p_lpcm) else $error("lpcm slot order wrong");

  property p_mst;
    audio_valid && mst_on |=> audio_word[63:32] == $past(audio_in[159:128]) && audio_word[223:192] == $past(audio_in[127:96]);
  endproperty
  a_mst: assert property (p_mst) else $error("multi-stream slot order wrong");

  property p_strobe;
    lane_strobe == $past(link_edge) && !(lane_strobe && $past(lane_strobe));
  endproperty
  a_strobe: assert property (p_strobe) else $error("link word strobe misplaced");

  property p_train;
    link_edge && !training_start |=> lane_data[39:0] == $past(pat_data[0]);
  endproperty
  a_train: assert property (p_train) else $error("training pattern not sent");

  property p_qual;
    !vid_valid |=> $stable(vid_word);
  endproperty
  a_qual: assert property (p_qual) else $error("unqualified video captured");

  property p_char;
    frl_char_req |-> $past(frl_on) && $past(training_start);
  endproperty
  a_char: assert property (p_char) else $error("character request misplaced");

  property p_drain;
    frl_on && training_start && st_r.char_acc >= CHAR_THR |=> frl_char_req;
  endproperty
  a_drain: assert property (p_drain) else $error("character deficit not drained");

  property p_lane3;
    link_edge && training_start && three_lane |=> st_r.lane[3] == 40'h0000000000;
  endproperty
  a_lane3: assert property (p_lane3) else $error("fourth lane not idle");

  property p_pix;
    vid_valid && !frl_on |=> vid_word[191:48] == '0;
  endproperty
  a_pix: assert property (p_pix) else $error("extra pixels kept");

endmodule
`default_nettype wire

// ---- sim/txl_xcvr_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// transceiver side model
// ****************************************
module txl_xcvr_model (
  // link clock
  output logic link_speed_clock
);
  // free-running transceiver clock, phase unrelated to aclk
  // only link clock supplied
  initial
  begin
    link_speed_clock = 1'b0;
    #1.3;
    forever #16 link_speed_clock = ~link_speed_clock;
  end
endmodule
`default_nettype wire

// ---- sim/test_tx_link_output_clocking.sv ----
`timescale 1ns/10ps
`default_nettype none
module test_tx_link_output_clocking;
  // ****************************************
  // signals
  // ****************************************
  logic         aclk = 0, aresetn = 0;
  logic [3:0]   s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 0;
  logic [31:0]  s_axi_wdata = 0, s_axi_rdata;
  logic         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  wire logic    link_speed_clock;
  logic         training_start = 0, lane_strobe, frl_char_req, vid_valid = 0, audio_valid = 0, audio_word_valid;
  logic [15:0]  lane_pattern = 0;
  logic [159:0] lane_data, e, me;
  logic [191:0] vid_data = 0, vid_word;
  logic [255:0] audio_in = 0, audio_word, ax;
  logic [5:0]   audio_first_channel;
  logic [1:0]   mk;
  logic [159:0] lq[$];
  logic [1:0]   lk[$];
  logic [255:0] aq[$];
  int           n_mismatch = 0, comparisons = 0, nstb = 0, nreq = 0, n0, cyc = 0;

  txl_xcvr_model xcvr (.link_speed_clock);
  txl_out #(.FRL_CHARS(8)) uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_speed_clock,
    .training_start, .lane_pattern, .lane_data, .lane_strobe, .frl_char_req, .vid_data, .vid_valid, .vid_word,
    .audio_in, .audio_valid, .audio_word, .audio_word_valid, .audio_first_channel);

  initial forever #2 aclk = ~aclk;

  // ****************************************
  // helpers
  // ****************************************
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [255:0] ex, input logic [255:0] got);
    comparisons++;
    if (got !== ex)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      n_mismatch++;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp("s_axi_bresp", txl_pkg::RESP_OKAY, s_axi_bresp);
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ex, input logic [31:0] msk);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp("s_axi_rdata", ex, s_axi_rdata & msk);
    cmp("s_axi_rresp", txl_pkg::RESP_OKAY, s_axi_rresp);
  endtask

  task automatic ws;
    do @(posedge aclk);
    while (lane_strobe !== 1'b1);
  endtask

  // settle two words, then note the expected lanes for the next word
  task automatic chk(input logic [159:0] ex, input logic [1:0] k);
    ws();
    ws();
    #1;
    lq.push_back(ex);
    lk.push_back(k);
    ws();
  endtask

  task automatic rv;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) vid_data[32*i+:32] <= $urandom();
    #1;
  endtask

  task automatic ra(input logic m);
    @(posedge aclk);
    for (int i = 0; i < 8; i++) audio_in[32*i+:32] <= $urandom();
    audio_valid <= 1'b1;
    #1;
    ax = audio_in;
    for (int s = 0; s < 4; s++) if (m) ax[64*s+:64] = {audio_in[32*(s+4)+:32], audio_in[32*s+:32]};
    aq.push_back(ax);
    @(posedge aclk);
    audio_valid <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask

  function automatic logic [159:0] vx(input logic [191:0] v, input logic frl, input logic three);
    if (frl) return three ? {40'h0, v[119:0]} : v[159:0];
    return {112'h0, v[47:0]};
  endfunction

  // ****************************************
  // monitor and timeout
  // ****************************************
  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_mismatch++;
      end_sim();
    end
    if (aresetn && frl_char_req === 1'b1) nreq++;
    if (aresetn && lane_strobe === 1'b1)
    begin
      if (lq.size() > 0)
      begin
        me = lq.pop_front();
        mk = lk.pop_front();
        if (mk == 2'h1) me[159:120] = {30'h0, (nstb % 4 < 2) ? txl_pkg::SYM_ZERO : txl_pkg::SYM_ONE};
        if (mk == 2'h2) me[159:120] = {20'h0, nstb[0] ? txl_pkg::W2_ONE : txl_pkg::W2_ZERO};
        cmp("lane_data", me, lane_data);
      end
      nstb++;
    end
    if (audio_word_valid === 1'b1 && aq.size() > 0) cmp("audio_word", aq.pop_front(), audio_word);
  end

  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    void'($urandom(45173));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(txl_pkg::OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    rd(txl_pkg::OFS_STATUS, 32'h1F, 32'h1F);
    wr(txl_pkg::OFS_STATUS, 32'hFFFFFFFF);
    rd(txl_pkg::OFS_CTRL, 32'h0, 32'hFFFFFFFF);
    lane_pattern <= {4'h7, txl_pkg::PAT_ALT, txl_pkg::PAT_ONE, txl_pkg::PAT_ZERO};
    chk({40'h0, txl_pkg::ALT_WORD, {40{1'b1}}, 40'h0}, 2'h0);
    training_start <= 1'b1;
    vid_valid <= 1'b1;
    rv();
    e = vx(vid_data, 1'b0, 1'b0);
    e[159:120] = {4{txl_pkg::SYM_CONST}};
    chk(e, 2'h0);
    vid_valid <= 1'b0;
    rv();
    chk(e, 2'h0);
    vid_valid <= 1'b1;
    for (int w = 0; w < 4; w++)
    begin
      wr(txl_pkg::OFS_CTRL, {26'h0, 2'(w), 2'h1});
      e = vx(vid_data, 1'b0, 1'b0);
      e[159:120] = txl_pkg::W4_WORD;
      chk(e, (w == 0) ? 2'h1 : (w == 1) ? 2'h2 : 2'h0);
    end
    for (int r = 2; r < 4; r++)
    begin
      wr(txl_pkg::OFS_CTRL, {25'h0, 3'(r), 4'h2});
      chk(vx(vid_data, 1'b1, r < 3), 2'h0);
      cmp("vid_word", vid_data, vid_word);
      // whole words only: 6 x 120 and 9 x 160 bits are whole batches
      @(posedge aclk);
      #1;
      n0 = nreq;
      repeat ((r < 3) ? 6 : 9) ws();
      @(posedge aclk);
      #1;
      cmp("frl_char_req", (r < 3) ? 5 : 10, nreq - n0);
    end
    wr(txl_pkg::OFS_CTRL, 32'h3FF);
    rd(txl_pkg::OFS_CTRL, 32'h3FF, 32'hFFFFFFFF);
    cmp("audio_first_channel", 25, audio_first_channel);
    wr(txl_pkg::OFS_CTRL, 32'h300);
    ra(1'b0);
    wr(txl_pkg::OFS_CTRL, 32'h380);
    ra(1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
